// >>> core/e3lr_pkg.sv
/*
 * e3lr_pkg: shared constants for the E3 receive link-message controller
 * and its framer-side feeder.
 * Assumes: one 125 MHz clock, synchronous active-high reset.
 */
package e3lr_pkg;
   // ==========================================================
   // register map (byte addresses on AHB-Lite)
   localparam logic [15:0] ADDR_CTRL = 16'h0000;
   localparam logic [15:0] ADDR_STATUS = 16'h0004;
   localparam logic [15:0] ADDR_IRQ_STAT = 16'h0008;
   localparam logic [15:0] ADDR_IRQ_MASK = 16'h000c;
   localparam logic [15:0] ADDR_COUNT = 16'h0010;
   localparam logic [15:0] ADDR_MSG_BUF = 16'h11c0;
   // ==========================================================
   // control fields
   localparam int CTRL_IRQ_EN = 1;
   localparam int CTRL_RX_EN = 2;
   localparam int CTRL_SEL_NETOP = 3;
   // status fields
   localparam int ST_FLAG_PRESENT = 0;
   localparam int ST_END_OF_MSG = 1;
   localparam int ST_FCS_ERR = 2;
   localparam int ST_ABORT = 6;
   // interrupt status fields
   localparam int IRQ_MSG_DONE = 0;
   localparam int IRQ_FCS_ERR = 1;
   localparam int IRQ_OVERRUN = 2;
   localparam int IRQ_W = 3;
   // ==========================================================
   // frame constants
   localparam logic [7:0] FLAG_OCTET = 8'h7e;
   localparam logic [7:0] ADDR_STD_CMD = 8'h3c;
   localparam logic [7:0] ADDR_STD_RSP = 8'h3e;
   localparam logic [7:0] TEI_STD = 8'h01;
   localparam logic [7:0] CTRL_UI = 8'h03;
   localparam logic [5:0] SERVICE_ACCESS_POINT_ID_STD = 6'h0f;
   localparam logic [15:0] FCS_POLY_REV = 16'h8408;
   localparam logic [15:0] FCS_INIT = 16'hffff;
   localparam logic [15:0] FCS_GOOD = 16'hf0b8;
   localparam int BUF_DEPTH = 90;
   localparam int MAX_PAYLOAD = 82;
   localparam int HDR_OCTETS = 3;
   localparam int FCS_OCTETS = 2;
   localparam int ONES_STUFF = 5;
   localparam int ONES_ABORT = 7;
   // ==========================================================
   typedef enum logic {E3LR_NETOP, E3LR_GENCOM} e3lr_sel_t;
endpackage : e3lr_pkg

// >>> core/e3lr_link_if.sv
/*
 * e3lr_link_if: per-frame overhead bytes from receive framer to controller.
 * Assumes: both ends on the same clock; frame_strobe is one cycle wide.
 */
`timescale 1ns/1ns
`default_nettype none
interface e3lr_link_if;
   logic frame_strobe;
   logic [7:0] network_operator_byte;
   logic [7:0] general_comms_byte;
   modport framer (output frame_strobe, output network_operator_byte,
      output general_comms_byte);
   modport ctrl (input frame_strobe, input network_operator_byte,
      input general_comms_byte);
endinterface : e3lr_link_if
`default_nettype wire

// >>> core/e3lr_framer_end.sv
/*
 * e3lr_framer_end: framer side; hands one overhead byte pair per E3 frame.
 * Assumes: user logic presents bytes with a one-cycle frame pulse; when no
 * message is sent the user fills the channel with flag octets.
 */
`timescale 1ns/1ns
`default_nettype none
module e3lr_framer_end (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic FRAME_I,
   input wire logic [7:0] NETOP_BYTE_I,
   input wire logic [7:0] GENCOM_BYTE_I,
   e3lr_link_if.framer link
);
   logic strobe, next_strobe;
   logic [7:0] netop, next_netop, gencom, next_gencom;
   // ==========================================================
   // registered hand-over; idle value is flag fill
   always_comb begin
      next_strobe = FRAME_I;
      next_netop = FRAME_I ? NETOP_BYTE_I : netop;
      next_gencom = FRAME_I ? GENCOM_BYTE_I : gencom;
   end
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         strobe <= 1'b0;
         netop <= e3lr_pkg::FLAG_OCTET;
         gencom <= e3lr_pkg::FLAG_OCTET;
      end else begin
         strobe <= next_strobe;
         netop <= next_netop;
         gencom <= next_gencom;
      end
   end
   assign link.frame_strobe = strobe;
   assign link.network_operator_byte = netop;
   assign link.general_comms_byte = gencom;
endmodule : e3lr_framer_end
`default_nettype wire

// >>> core/e3lr_rx_ctrl.sv
/*
 * e3lr_rx_ctrl: receive link-message controller with AHB-Lite registers.
 * Assumes: link bytes arrive on the same clock; one AHB master, single
 * word transfers; read of message buffer pops one octet.
 */
// Functional notes
// - messages held in 90-byte FIFO at 0x11C0
// - one byte per frame from chosen overhead
// - standard and non-standard messages up to 82
// - payload 76, 82 or any up to 82
// - flag, address, terminal id, control, payload, check
// - octet 0x7E marks frame boundaries
// - idle channel carries continuous flag octets
// - standard address 0x3C/0x3E, terminal octet 0x01
// - standard service identifier is binary 001111
// - terminal endpoint identifier carries zero
// - standard control octet equals 0x03
// - CRC-16 x16+x12+x5+1 over header and payload
// - recompute check, compare, flag errors
// - select bit 1 network-operator, 0 general-comms
// - extraction only after receive enable set
// - flag-present status while flags arrive
// - interrupt on each completed new message
`timescale 1ns/1ns
`default_nettype none
module e3lr_rx_ctrl #(
   parameter int DEPTH = e3lr_pkg::BUF_DEPTH,
   parameter int MAX_LEN = e3lr_pkg::MAX_PAYLOAD
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   e3lr_link_if.ctrl link,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   output logic IRQ_O
);
   localparam int AW = $clog2(DEPTH + 1);
   localparam int LW = $clog2(MAX_LEN + e3lr_pkg::HDR_OCTETS
      + e3lr_pkg::FCS_OCTETS + 2);
   initial begin
      if (DEPTH < MAX_LEN + e3lr_pkg::HDR_OCTETS + 2 || MAX_LEN < 1)
         $error("e3lr_rx_ctrl: buffer too small for a message");
   end
   // ==========================================================
   // register state
   logic [7:0] ctrl, next_ctrl;
   logic [e3lr_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
   logic [e3lr_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
   logic eom, next_eom, fcs_err, next_fcs_err, abort, next_abort;
   logic flag_seen, next_flag_seen;
   logic [31:0] rdata, next_rdata;
   logic irq, next_irq;
   logic ap_valid, next_ap_valid, ap_write, next_ap_write;
   logic [15:0] ap_addr, next_ap_addr;
   // ==========================================================
   // bit engine: bytes are shifted lsb first, one bit per clock
   logic [7:0] shreg, next_shreg;
   logic [3:0] bitcnt, next_bitcnt;
   logic [7:0] rawbyte, next_rawbyte;
   logic [2:0] ones, next_ones;
   logic [7:0] octet, next_octet;
   logic [2:0] obits, next_obits;
   logic [7:0] flagwin, next_flagwin;
   logic in_frame, next_in_frame;
   logic [15:0] crc, next_crc;
   // check value at the last octet boundary; the closing flag's first
   // seven bits have already run through crc when the flag is recognised
   logic [15:0] crc_oct, next_crc_oct;
   logic [LW-1:0] flen, next_flen;
   logic [7:0] hold0, next_hold0, hold1, next_hold1;
   // ==========================================================
   // message buffer, a circular FIFO
   logic [7:0] mem [DEPTH];
   logic [AW-1:0] wptr, next_wptr, rptr, next_rptr, cnt, next_cnt;
   logic [AW-1:0] fstart, next_fstart;
   logic wr_en;
   logic [7:0] wr_data;
   logic pop;
   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : inc
   // ==========================================================
   // bit processing
   logic bit_v, b;
   logic eom_set;
   logic [e3lr_pkg::IRQ_W-1:0] irq_ev;
   always_comb begin
      next_bitcnt = bitcnt;
      next_rawbyte = rawbyte;
      next_shreg = shreg;
      next_ones = ones;
      next_octet = octet;
      next_obits = obits;
      next_flagwin = flagwin;
      next_in_frame = in_frame;
      next_crc = crc;
      next_crc_oct = crc_oct;
      next_flen = flen;
      next_hold0 = hold0;
      next_hold1 = hold1;
      next_fstart = fstart;
      eom_set = 1'b0;
      next_fcs_err = fcs_err;
      next_abort = abort;
      next_flag_seen = flag_seen;
      irq_ev = '0;
      wr_en = 1'b0;
      wr_data = 8'h00;
      bit_v = 1'b0;
      b = 1'b0;
      if (link.frame_strobe && ctrl[e3lr_pkg::CTRL_RX_EN]) begin
         next_rawbyte = ctrl[e3lr_pkg::CTRL_SEL_NETOP] ?
            link.network_operator_byte : link.general_comms_byte;
         next_bitcnt = 4'h8;
      end else if (bitcnt != 4'h0) begin
         bit_v = 1'b1;
         b = rawbyte[0];
         next_rawbyte = {1'b0, rawbyte[7:1]};
         next_bitcnt = bitcnt - 4'h1;
      end
      if (!ctrl[e3lr_pkg::CTRL_RX_EN]) begin
         next_in_frame = 1'b0;
         next_flag_seen = 1'b0;
      end
      if (bit_v) begin
         next_flagwin = {b, flagwin[7:1]};
         next_ones = b ? ((ones == 3'(e3lr_pkg::ONES_ABORT)) ? ones
            : ones + 3'h1) : 3'h0;
         if (next_flagwin == e3lr_pkg::FLAG_OCTET) begin
            // closing flag: the last two stored octets are the check
            // flags may sit at any bit offset of the raw bytes
            next_flag_seen = 1'b1;
            // any payload length up to MAX_LEN ends at the flag
            if (in_frame && obits == 3'h7 && flen >= LW'(e3lr_pkg::HDR_OCTETS
               + e3lr_pkg::FCS_OCTETS)) begin
               eom_set = 1'b1;
               next_fcs_err = (crc_oct != e3lr_pkg::FCS_GOOD);
               next_abort = 1'b0;
               next_fstart = wptr;
               irq_ev[e3lr_pkg::IRQ_MSG_DONE] = 1'b1;
               if (next_fcs_err)
                  irq_ev[e3lr_pkg::IRQ_FCS_ERR] = 1'b1;
            end
            next_in_frame = 1'b1;
            next_obits = 3'h0;
            next_flen = '0;
            next_crc = e3lr_pkg::FCS_INIT;
            next_crc_oct = e3lr_pkg::FCS_INIT;
         end else if (ones == 3'(e3lr_pkg::ONES_STUFF) && !b) begin
            // stuffed zero dropped
         end else if (next_ones == 3'(e3lr_pkg::ONES_ABORT)) begin
            if (in_frame && flen != '0)
               next_abort = 1'b1;
            next_in_frame = 1'b0;
         end else if (in_frame) begin
            // crc over every data bit incl. check octets
            next_crc = {1'b0, crc[15:1]} ^
               ((crc[0] ^ b) ? e3lr_pkg::FCS_POLY_REV : 16'h0000);
            next_octet = {b, octet[7:1]};
            next_obits = obits + 3'h1;
            if (obits == 3'h7) begin
               next_crc_oct = next_crc;
               next_flag_seen = 1'b0;
               // header octets kept as received
               next_hold1 = hold0;
               next_hold0 = next_octet;
               // two-octet delay keeps check octets out of the buffer
               if (flen >= LW'(e3lr_pkg::FCS_OCTETS)) begin
                  if (flen >= LW'(MAX_LEN + e3lr_pkg::HDR_OCTETS
                     + e3lr_pkg::FCS_OCTETS)) begin
                     next_in_frame = 1'b0;
                     next_abort = 1'b1;
                  end else if (cnt == AW'(DEPTH)) begin
                     next_in_frame = 1'b0;
                     irq_ev[e3lr_pkg::IRQ_OVERRUN] = 1'b1;
                  end else begin
                     wr_en = 1'b1;
                     wr_data = hold1;
                  end
               end
               next_flen = flen + LW'(1);
            end
         end
      end
      // unfinished frame octets stay in the buffer on abort; wptr is not rewound
      if (!next_in_frame && in_frame && !eom_set)
         next_fstart = fstart;
   end
   // ==========================================================
   // AHB-Lite slave, zero wait states
   logic rd_hit;
   always_comb begin
      next_ap_valid = HSEL_I && HREADY_I && HTRANS_I[1];
      next_ap_write = HWRITE_I;
      next_ap_addr = HADDR_I[15:0];
      next_ctrl = ctrl;
      next_irq_mask = irq_mask;
      next_rdata = rdata;
      pop = 1'b0;
      rd_hit = ap_valid && !ap_write;
      if (ap_valid && ap_write) begin
         unique case (ap_addr)
            e3lr_pkg::ADDR_CTRL: next_ctrl = HWDATA_I[7:0];
            e3lr_pkg::ADDR_IRQ_MASK:
               next_irq_mask = HWDATA_I[e3lr_pkg::IRQ_W-1:0];
            default: ;
         endcase
      end
      if (next_ap_valid && !HWRITE_I) begin
         unique case (HADDR_I[15:0])
            e3lr_pkg::ADDR_CTRL: next_rdata = {24'h0, ctrl};
            e3lr_pkg::ADDR_STATUS: next_rdata = {25'h0, abort, 3'h0,
               fcs_err, eom, flag_seen};
            e3lr_pkg::ADDR_IRQ_STAT: next_rdata = 32'(irq_stat);
            e3lr_pkg::ADDR_IRQ_MASK: next_rdata = 32'(irq_mask);
            e3lr_pkg::ADDR_COUNT: next_rdata = 32'(cnt);
            e3lr_pkg::ADDR_MSG_BUF: begin
               // octets up to the last completed message are visible, incl. aborted-frame leftovers before it
               next_rdata = (rptr != fstart || cnt == AW'(DEPTH)) ?
                  {24'h0, mem[rptr]} : 32'h0;
               pop = (rptr != fstart || cnt == AW'(DEPTH));
            end
            default: next_rdata = 32'h0;
         endcase
      end
      // read clears; a same-cycle event still sets
      next_irq_stat = ((rd_hit && ap_addr == e3lr_pkg::ADDR_IRQ_STAT) ?
         '0 : irq_stat) | irq_ev;
      next_eom = ((rd_hit && ap_addr == e3lr_pkg::ADDR_STATUS) ?
         1'b0 : eom) | eom_set;
      next_irq = |(next_irq_stat & next_irq_mask) &&
         next_ctrl[e3lr_pkg::CTRL_IRQ_EN];
      next_wptr = wr_en ? inc(wptr) : wptr;
      next_rptr = pop ? inc(rptr) : rptr;
      next_cnt = cnt + AW'(wr_en) - AW'(pop);
   end
   // ==========================================================
   always_ff @(posedge CLOCK_I) begin
      if (wr_en)
         mem[wptr] <= wr_data;
   end
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ctrl <= 8'h00;
         irq_stat <= '0;
         irq_mask <= '0;
         eom <= 1'b0;
         fcs_err <= 1'b0;
         abort <= 1'b0;
         flag_seen <= 1'b0;
         rdata <= 32'h0;
         irq <= 1'b0;
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr <= 16'h0;
         shreg <= 8'h00;
         bitcnt <= 4'h0;
         rawbyte <= 8'h00;
         ones <= 3'h0;
         octet <= 8'h00;
         obits <= 3'h0;
         flagwin <= 8'h00;
         in_frame <= 1'b0;
         crc <= e3lr_pkg::FCS_INIT;
         crc_oct <= e3lr_pkg::FCS_INIT;
         flen <= '0;
         hold0 <= 8'h00;
         hold1 <= 8'h00;
         wptr <= '0;
         rptr <= '0;
         cnt <= '0;
         fstart <= '0;
      end else begin
         ctrl <= next_ctrl;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         eom <= next_eom;
         fcs_err <= next_fcs_err;
         abort <= next_abort;
         flag_seen <= next_flag_seen;
         rdata <= next_rdata;
         irq <= next_irq;
         ap_valid <= next_ap_valid;
         ap_write <= next_ap_write;
         ap_addr <= next_ap_addr;
         shreg <= next_shreg;
         bitcnt <= next_bitcnt;
         rawbyte <= next_rawbyte;
         ones <= next_ones;
         octet <= next_octet;
         obits <= next_obits;
         flagwin <= next_flagwin;
         in_frame <= next_in_frame;
         crc <= next_crc;
         crc_oct <= next_crc_oct;
         flen <= next_flen;
         hold0 <= next_hold0;
         hold1 <= next_hold1;
         wptr <= next_wptr;
         rptr <= next_rptr;
         cnt <= next_cnt;
         fstart <= next_fstart;
      end
   end
   assign HRDATA_O = rdata;
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;
   assign IRQ_O = irq;
endmodule : e3lr_rx_ctrl
`default_nettype wire

// >>> testbench/e3lr_link_monitor.sv
/* e3lr_link_monitor: assertions on the overhead-byte link between ends.
 * Assumes: instantiated beside the link interface, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module e3lr_link_monitor (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic frame_strobe,
   input wire logic [7:0] network_operator_byte,
   input wire logic [7:0] general_comms_byte
);
   default clocking mon_cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I);
   // ==========
   // sequences
   sequence s_quiet;
      !frame_strobe [*8];
   endsequence
   sequence s_bytes_held;
      ($stable(network_operator_byte) && $stable(general_comms_byte)) [*8];
   endsequence
   sequence s_idle_flags;
      network_operator_byte == 8'h7e && general_comms_byte == 8'h7e;
   endsequence
   // ==========
   // checks
   strobe_pulse_a: assert property (
      frame_strobe |=> s_quiet)
      else $error("frame strobe too wide or frames too close");
   netop_hold_a: assert property (
      !frame_strobe |-> $stable(network_operator_byte))
      else $error("operator byte changed without a frame strobe");
   gencom_hold_a: assert property (
      !frame_strobe |-> $stable(general_comms_byte))
      else $error("comms byte changed without a frame strobe");
   reset_idle_a: assert property (
      disable iff (1'b0) RST_I |=> !frame_strobe ##0 s_idle_flags)
      else $error("link not idle with flags during reset");
   bytes_held_a: assert property (frame_strobe |=> s_bytes_held)
      else $error("overhead bytes changed while being shifted");
   strobe_single_a: assert property (frame_strobe |=> !frame_strobe)
      else $error("frame strobe longer than one cycle");
   frame_seen_c: cover property (frame_strobe ##1 s_quiet);
endmodule : e3lr_link_monitor
`default_nettype wire

// >>> testbench/e3lr_rx_lapd_path_maintenance_message_receiver_tb.sv
/* e3lr_rx_lapd_path_maintenance_message_receiver_tb: both ends joined, AHB-Lite master, model.
 * Assumes: core/ package, interface and both ends compiled first. */
`timescale 1ns/1ns
`default_nettype none
module e3lr_rx_lapd_path_maintenance_message_receiver_tb;
   logic clk = 0;
   logic rst = 1;
   logic frame = 0;
   logic [7:0] netop = 8'h7e;
   logic [7:0] gencom = 8'h7e;
   logic hsel = 0;
   logic hwrite = 0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   wire logic [31:0] hrdata;
   wire logic hready;
   wire logic hresp;
   wire logic irq;
   int miscompares = 0;
   int compares = 0;
   int ones = 0;
   logic [7:0] exp_q[$];
   bit bits[$];
   logic [31:0] rd;
   always #4 clk = ~clk;
   e3lr_link_if link ();
   e3lr_framer_end i_e3lr_framer_end (.CLOCK_I(clk), .RST_I(rst),
      .FRAME_I(frame), .NETOP_BYTE_I(netop), .GENCOM_BYTE_I(gencom),
      .link(link));
   e3lr_rx_ctrl i_e3lr_rx_ctrl (.CLOCK_I(clk), .RST_I(rst), .link(link),
      .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
      .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .IRQ_O(irq));
   e3lr_link_monitor i_e3lr_link_monitor (.CLOCK_I(clk), .RST_I(rst),
      .frame_strobe(link.frame_strobe),
      .network_operator_byte(link.network_operator_byte),
      .general_comms_byte(link.general_comms_byte));
   // ==========
   // reporting
   task automatic complete_run;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // ==========
   // bus master
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 64) begin
            miscompares++;
            complete_run();
         end
         @(posedge clk);
      end
   endtask : wait_ready
   task automatic ahb(input logic w, input logic [15:0] a,
      input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {16'h0, a};
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : ahb
   // ==========
   // link stream model: continuous bit stream, lsb first, zero stuffing
   function automatic logic [15:0] fcs(input logic [15:0] c,
      input logic [7:0] o);
      c = c ^ {8'h0, o};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? (c >> 1) ^ e3lr_pkg::FCS_POLY_REV : c >> 1;
      end
      return c;
   endfunction : fcs
   task automatic put_octet(input logic [7:0] b, input bit stuff);
      for (int i = 0; i < 8; i++) begin
         bits.push_back(b[i]);
         ones = (b[i] && stuff) ? ones + 1 : 0;
         if (ones == 5) begin
            bits.push_back(1'b0);
            ones = 0;
         end
      end
   endtask : put_octet
   // leftover bits stay queued so the stream never breaks between calls
   task automatic flush(input bit sel);
      logic [7:0] b;
      while (bits.size() >= 8) begin
         for (int i = 0; i < 8; i++) begin
            b[i] = bits.pop_front();
         end
         frame <= 1'b1;
         netop <= sel ? b : 8'($urandom);
         gencom <= sel ? 8'($urandom) : b;
         @(posedge clk);
         frame <= 1'b0;
         repeat (11) @(posedge clk);
      end
   endtask : flush
   task automatic send_msg(input int len, input bit sel, input bit bad,
      input bit std);
      logic [15:0] crc;
      logic [7:0] o;
      crc = e3lr_pkg::FCS_INIT;
      put_octet(e3lr_pkg::FLAG_OCTET, 0);
      for (int i = 0; i < len + 3; i++) begin
         o = 8'($urandom);
         if (std && i == 0) o = len[0] ? e3lr_pkg::ADDR_STD_RSP
            : e3lr_pkg::ADDR_STD_CMD;
         if (std && i == 1) o = e3lr_pkg::TEI_STD;
         if (std && i == 2) o = e3lr_pkg::CTRL_UI;
         exp_q.push_back(o);
         put_octet(o, 1);
         crc = fcs(crc, o);
      end
      crc = ~crc ^ {15'h0, bad};
      put_octet(crc[7:0], 1);
      put_octet(crc[15:8], 1);
      repeat (3) put_octet(e3lr_pkg::FLAG_OCTET, 0);
      flush(sel);
   endtask : send_msg
   // ==========
   // main sequence
   initial begin
      int lens[6];
      int n;
      bit sel;
      void'($urandom(32'h5ca842e9));
      lens = '{76, 82, 1, 0, 40, 20};
      lens[3] = 2 + ($urandom % 80);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      ahb(0, e3lr_pkg::ADDR_CTRL, 0);
      check(rd, 0);
      send_msg(10, 1, 0, 1);
      exp_q.delete();
      ahb(0, e3lr_pkg::ADDR_COUNT, 0);
      check(rd, 0);
      ahb(0, 16'h0020, 0);
      check(rd, 0);
      for (int k = 0; k < 6; k++) begin
         sel = !k[0];
         ahb(1, e3lr_pkg::ADDR_CTRL, {28'h0, sel, 3'b110});
         ahb(1, e3lr_pkg::ADDR_IRQ_MASK, (k == 5) ? 32'h0 : 32'h7);
         send_msg(lens[k], sel, k == 4, k != 3);
         for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge clk);
         check(irq, k != 5);
         ahb(0, e3lr_pkg::ADDR_IRQ_STAT, 0);
         check(rd, {30'h0, k == 4, 1'b1});
         ahb(0, e3lr_pkg::ADDR_STATUS, 0);
         check(rd[2:0], {k == 4, 2'b11});
         check(irq, 0);
         ahb(0, e3lr_pkg::ADDR_COUNT, 0);
         check(rd, exp_q.size());
         while (exp_q.size() > 0) begin
            ahb(0, e3lr_pkg::ADDR_MSG_BUF, 0);
            check(rd, {24'h0, exp_q.pop_front()});
         end
         ahb(0, e3lr_pkg::ADDR_MSG_BUF, 0);
         check(rd, 0);
         check(hresp, 0);
      end
      complete_run();
   end
endmodule : e3lr_rx_lapd_path_maintenance_message_receiver_tb
`default_nettype wire
